// ===== prl_pkg.sv
/*
 * shared constants for the port register and io logic block
 * assumes a 4-bit data memory bus from the core, one clock domain
 */
package prl_pkg;
    // data width of a port register
    localparam int NIB_W = 4;
    // port selects on the core side data memory port
    localparam logic [3:0] SEL_PORT_A = 4'h0;
    localparam logic [3:0] SEL_PORT_B = 4'h1;
    localparam logic [3:0] SEL_PORT_C = 4'h2;
    localparam logic [3:0] SEL_PORT_D = 4'h3;
    localparam logic [3:0] SEL_OUT_ONE = 4'h4;
    localparam logic [3:0] SEL_OUT_TWO = 4'h5;
    localparam logic [3:0] SEL_LAST = 4'h6;
    localparam logic [3:0] SEL_LCD_ONE = 4'h7;
    localparam logic [3:0] SEL_LCD_TWO = 4'h8;
    localparam logic [3:0] SEL_LCD_X_LO = 4'h9;
    localparam logic [3:0] SEL_LCD_X_HI = 4'hA;
    localparam logic [3:0] SEL_LCD_Y0 = 4'hB;
    localparam logic [3:0] SEL_LCD_Y1 = 4'hC;
    localparam logic [3:0] SEL_LCD_Y2 = 4'hD;
    localparam logic [3:0] SEL_LCD_Y3 = 4'hE;
    // index of the sda and scl pins inside bidir port a
    localparam int SDA_BIT = 3;
    localparam int SCL_BIT = 2;
    // direction reset value: all inputs
    localparam logic [3:0] DIR_RESET = 4'h0;
    // latch reset value for lcd-shared ports
    localparam logic [3:0] LCD_RESET = 4'h0;
    // group widths
    localparam int X_W = 6;
    localparam int Y_W = 16;
endpackage

// ===== prl_port_io.sv
/*
 * port register and pin logic of a 4-bit controller: four bidirectional
 * ports, two output-only ports, one last port and four lcd-shared ports.
 * every port register sits in data memory and is reached by a select code.
 * pins are split into separate in, out and enable ports; the pad ring
 * combines them, and the sda and scl pads are open drain on the board.
 * assumes the core issues one data memory access per cycle with a port
 * select, and that lcd segment drive comes from an lcd driver elsewhere.
 * assumes ce reset and clock stop arrive as levels on the core clock,
 * while the pin inputs are asynchronous and synchronised here.
 */
`timescale 1ns/1ps
module prl_port_io
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce_reset,
    input wire logic clk_stop,
    input wire logic mem_wr,
    input wire logic [3:0] mem_sel,
    input wire logic [3:0] mem_wdata,
    output logic [3:0] mem_rdata,
    input wire logic [3:0] dir_wr,
    input wire logic [3:0] dir_wdata,
    input wire logic [3:0] lcd_port_sel,
    input wire logic [29:0] lcd_seg,
    input wire logic [3:0] port_a_in,
    output logic [3:0] port_a_out,
    output logic [3:0] port_a_oe,
    input wire logic [3:0] port_b_in,
    output logic [3:0] port_b_out,
    output logic [3:0] port_b_oe,
    input wire logic [3:0] port_c_in,
    output logic [3:0] port_c_out,
    output logic [3:0] port_c_oe,
    input wire logic [3:0] port_d_in,
    output logic [3:0] port_d_out,
    output logic [3:0] port_d_oe,
    output logic [3:0] out_one_pins,
    output logic [3:0] out_two_pins,
    output logic [3:0] last_pins,
    output logic [29:0] seg_pins
);
    import prl_pkg::*;

    // bidir output latches, one nibble per port, msb is the highest pin
    logic [3:0] bidir_q [4];
    // direction bits per bidir port, 1 = output
    // a whole port shares one direction bit, so a nibble turns together
    logic [3:0] dir_q;
    // two-stage pin synchronisers
    // reads of an input port therefore lag the pins by two cycles
    logic [3:0] pin_s1_q [4];
    logic [3:0] pin_s2_q [4];
    // output-only latches
    logic [3:0] out_one_q; // first output-only port
    logic [3:0] out_two_q; // second output-only port
    logic [3:0] last_q; // last port, output only
    // lcd-shared latches (dot registers and group registers)
    logic [3:0] lcd_one_q; // first dot register
    logic [3:0] lcd_two_q; // second dot register
    logic [X_W-1:0] lcd_x_q; // six-bit group, written in two nibbles
    logic [Y_W-1:0] lcd_y_q; // sixteen-bit group, written in four nibbles
    // core writes are blocked while ce reset or clock stop is active
    logic wr_ok;
    // forced-input condition for bidir pins
    logic force_in;
    // effective direction: the stored bit, cleared while forced to input
    logic [3:0] dir_eff;
    // raw pin array for looping
    logic [3:0] pin_raw [4];

    // one gate for every port write keeps the freeze rule in a single place
    assign wr_ok = mem_wr && !ce_reset && !clk_stop;
    // power-on reset needs no term here: it clears the direction bits
    assign force_in = ce_reset || clk_stop;
    // reads and pin enables both use this, so they always agree
    assign dir_eff = force_in ? 4'h0 : dir_q;
    // port order in the array follows the select codes
    assign pin_raw[0] = port_a_in;
    assign pin_raw[1] = port_b_in;
    assign pin_raw[2] = port_c_in;
    assign pin_raw[3] = port_d_in;

    // synchronise pins; the first stage feeds only the second
    // the reset value is low, which matches an undriven input pad;
    // a pin that changes on the sampling edge may be seen one cycle later
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                pin_s1_q[i] <= 4'h0;
                pin_s2_q[i] <= 4'h0;
            end
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                pin_s1_q[i] <= pin_raw[i];
                pin_s2_q[i] <= pin_s1_q[i];
            end
        end
    end

    // direction control, reset to input; held during ce reset and stop
    // each strobe bit writes only its own port's direction, so software
    // can turn one port without a read-modify-write of the others
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dir_q <= DIR_RESET;
        end
        // direction writes are ignored while forced, like port writes
        else if (!force_in)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (dir_wr[i])
                begin
                    dir_q[i] <= dir_wdata[i];
                end
            end
        end
    end

    // bidir latches: written whatever the direction; power-on value is
    // left zero here though software must not rely on it
    // writing the latch while the port is still an input lets software
    // preset the level, so turning to output gives no glitch
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                bidir_q[i] <= 4'h0;
            end
        end
        else if (wr_ok)
        begin
            for (int i = 0; i < 4; i++)
            begin
                // only the selected port's latch moves
                if (mem_sel == 4'(i))
                begin
                    bidir_q[i] <= mem_wdata;
                end
            end
        end
    end

    // output-only latches hold across ce reset and clock stop
    // power-on clears them, although the pins' power-on level is not
    // promised to software; zero was chosen so the pins start quiet
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            out_one_q <= 4'h0;
            out_two_q <= 4'h0;
            last_q <= 4'h0;
        end
        else if (wr_ok)
        begin
            case (mem_sel)
                SEL_OUT_ONE: out_one_q <= mem_wdata;
                SEL_OUT_TWO: out_two_q <= mem_wdata;
                SEL_LAST: last_q <= mem_wdata;
                // other selects belong to other latches
                default: ;
            endcase
        end
    end

    // lcd-shared latches, loaded through dot and group registers
    // the group registers are split into nibbles; a partial group update
    // reaches the pins at once, so a group shown as a port passes through
    // a mix of old and new nibbles while software writes it, in any order
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lcd_one_q <= LCD_RESET;
            lcd_two_q <= LCD_RESET;
            lcd_x_q <= '0;
            lcd_y_q <= '0;
        end
        else if (wr_ok)
        begin
            case (mem_sel)
                SEL_LCD_ONE: lcd_one_q <= mem_wdata;
                SEL_LCD_TWO: lcd_two_q <= mem_wdata;
                SEL_LCD_X_LO: lcd_x_q[3:0] <= mem_wdata;
                SEL_LCD_X_HI: lcd_x_q[5:4] <= mem_wdata[1:0];
                SEL_LCD_Y0: lcd_y_q[3:0] <= mem_wdata;
                SEL_LCD_Y1: lcd_y_q[7:4] <= mem_wdata;
                SEL_LCD_Y2: lcd_y_q[11:8] <= mem_wdata;
                SEL_LCD_Y3: lcd_y_q[15:12] <= mem_wdata;
                // other selects belong to other latches
                default: ;
            endcase
        end
    end

    // pin drive for bidir ports; oe drops when forced to input
    // the data outputs show the latch even while the enable is low, so the
    // pad sees the right level in the very cycle the enable rises
    always_comb
    begin
        port_a_out = bidir_q[0];
        port_b_out = bidir_q[1];
        port_c_out = bidir_q[2];
        port_d_out = bidir_q[3];
        port_a_oe = dir_eff[0] ? 4'hF : 4'h0;
        port_b_oe = dir_eff[1] ? 4'hF : 4'h0;
        port_c_oe = dir_eff[2] ? 4'hF : 4'h0;
        port_d_oe = dir_eff[3] ? 4'hF : 4'h0;
        // output-only pins follow their latches in every mode
        out_one_pins = out_one_q;
        out_two_pins = out_two_q;
        last_pins = last_q;
    end

    // the reset term is explicit because a segment group that is not a
    // port would otherwise pass the lcd driver's signal during reset
    // lcd-shared pins: low in power-on reset (latches zero) or stop,
    // else latch data when the group is a port, else segment signal
    always_comb
    begin
        logic [29:0] port_val;
        port_val = {lcd_two_q, lcd_one_q, lcd_x_q, lcd_y_q};
        seg_pins = 30'h0;
        if (!clk_stop)
        begin
            // each group picks its source from its own select bit
            seg_pins[15:0] = lcd_port_sel[3] ? port_val[15:0] : lcd_seg[15:0];
            seg_pins[21:16] = lcd_port_sel[2] ? port_val[21:16] : lcd_seg[21:16];
            seg_pins[25:22] = lcd_port_sel[0] ? port_val[25:22] : lcd_seg[25:22];
            seg_pins[29:26] = lcd_port_sel[1] ? port_val[29:26] : lcd_seg[29:26];
        end
        if (!rstn)
        begin
            seg_pins = 30'h0;
        end
    end

    // read mux; bidir reads follow direction except sda/scl
    // a port forced to input reads its pins, as an input port would
    // the sda and scl bits always read the pad, so a device on the bus that
    // holds a line low shows up even while this side drives it high
    // unused select codes read zero and have no side effect
    always_comb
    begin
        mem_rdata = 4'h0;
        case (mem_sel)
            SEL_PORT_A, SEL_PORT_B, SEL_PORT_C, SEL_PORT_D:
            begin
                mem_rdata = dir_eff[mem_sel[1:0]] ? bidir_q[mem_sel[1:0]]
                                                  : pin_s2_q[mem_sel[1:0]];
                if (mem_sel == SEL_PORT_A)
                begin
                    mem_rdata[SDA_BIT] = pin_s2_q[0][SDA_BIT];
                    mem_rdata[SCL_BIT] = pin_s2_q[0][SCL_BIT];
                end
            end
            SEL_OUT_ONE: mem_rdata = out_one_q;
            SEL_OUT_TWO: mem_rdata = out_two_q;
            SEL_LAST: mem_rdata = last_q;
            // dot and group registers read back what was written
            SEL_LCD_ONE: mem_rdata = lcd_one_q;
            SEL_LCD_TWO: mem_rdata = lcd_two_q;
            SEL_LCD_X_LO: mem_rdata = lcd_x_q[3:0];
            // upper two bits of the six-bit group's high nibble read as zero
            SEL_LCD_X_HI: mem_rdata = {2'h0, lcd_x_q[5:4]};
            SEL_LCD_Y0: mem_rdata = lcd_y_q[3:0];
            SEL_LCD_Y1: mem_rdata = lcd_y_q[7:4];
            SEL_LCD_Y2: mem_rdata = lcd_y_q[11:8];
            SEL_LCD_Y3: mem_rdata = lcd_y_q[15:12];
            default: mem_rdata = 4'h0;
        endcase
    end
endmodule

// ===== prl_assertions.sv
/* checker on the pins and data memory port of the port block
   assumes one clock and the async low power-on reset */
`timescale 1ns/1ps
module prl_assertions
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce_reset,
    input wire logic clk_stop,
    input wire logic mem_wr,
    input wire logic [3:0] mem_sel,
    input wire logic [3:0] mem_wdata,
    input wire logic [3:0] mem_rdata,
    input wire logic [3:0] port_a_in,
    input wire logic [3:0] port_a_out,
    input wire logic [3:0] port_a_oe,
    input wire logic [3:0] out_one_pins,
    input wire logic [29:0] seg_pins
);
    import prl_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ce reset or clock stop: writes blocked, pins forced
    wire hold = ce_reset | clk_stop;
    AST_WR_A: assert property (mem_wr && mem_sel == SEL_PORT_A && !hold
        |=> port_a_out == $past(mem_wdata)) else $error("latch not loaded");
    AST_HOLD: assert property (hold
        |=> $stable(port_a_out) && $stable(out_one_pins)) else $error("latch moved");
    AST_RD_OUT: assert property (mem_sel == SEL_OUT_ONE
        |-> mem_rdata == out_one_pins) else $error("bad read");
    AST_RD_LAT: assert property (mem_sel == SEL_PORT_A && port_a_oe == 4'hF
        |-> mem_rdata[1:0] == port_a_out[1:0]) else $error("bad latch read");
    // reading pins needs two live edges, as the synchroniser is two deep
    AST_RD_PIN: assert property (mem_sel == SEL_PORT_A && port_a_oe == 4'h0 && !hold
        && $past(rstn) && $past(rstn, 2) |-> mem_rdata == $past(port_a_in, 2))
        else $error("bad pin read");
    AST_SDA: assert property (mem_sel == SEL_PORT_A && port_a_oe == 4'hF
        && $past(rstn) && $past(rstn, 2)
        |-> (mem_rdata & 4'hC) == ($past(port_a_in, 2) & 4'hC)) else $error("bad bus read");
    AST_OE_OFF: assert property (hold |-> port_a_oe == 4'h0) else $error("pin driven");
    AST_LCD_LOW: assert property (clk_stop |-> seg_pins == 30'h0) else $error("seg high");
    cover property (mem_wr && hold);
    cover property (port_a_oe == 4'hF && mem_sel == SEL_PORT_A);
    cover property (clk_stop);
endmodule
bind prl_port_io prl_assertions chk (.clk, .rstn, .ce_reset, .clk_stop, .mem_wr, .mem_sel,
    .mem_wdata, .mem_rdata, .port_a_in, .port_a_out, .port_a_oe, .out_one_pins, .seg_pins);

// ===== prl_pins_model.sv
/* board side of the four bidirectional ports
   assumes ext is what the board holds on a released pin */
`timescale 1ns/1ps
module prl_pins_model
(
    input wire logic [15:0] oe,
    input wire logic [15:0] drv,
    input wire logic [15:0] ext,
    output logic [15:0] pin
);
    import prl_pkg::*;
    // sda and scl of port a are open drain: the board can hold them low
    localparam logic [15:0] OD_MASK = (16'h0001 << SDA_BIT) | (16'h0001 << SCL_BIT);
    // a driven pin shows the chip's own level, else the board level;
    // on the open-drain bits a low from the board wins over a driven high
    assign pin = (oe & drv & (ext | ~OD_MASK)) | (~oe & ext);
endmodule

// ===== tb_port_register_io_logic.sv
/* random port traffic plus hold, stop and segment cases
   assumes the pin model and the bound checker */
`timescale 1ns/1ps
module tb_port_register_io_logic;
    import prl_pkg::*;
    logic clk = 1'h0, rstn = 1'h0, ce_reset = 1'h0, clk_stop = 1'h0, mem_wr = 1'h0;
    logic [3:0] mem_sel = '0, mem_wdata = '0, dir_wr = '0, dir_wdata = '0, lcd_port_sel = '0;
    logic [29:0] lcd_seg = '0;
    logic [15:0] ext = '0;
    wire [3:0] mem_rdata, port_a_out, port_b_out, port_c_out, port_d_out, out_one_pins;
    wire [3:0] port_a_oe, port_b_oe, port_c_oe, port_d_oe, out_two_pins, last_pins;
    wire [29:0] seg_pins;
    wire [15:0] pin_v;
    wire [15:0] oev = {port_d_oe, port_c_oe, port_b_oe, port_a_oe};
    wire [27:0] pv = {last_pins, out_two_pins, out_one_pins, port_d_out, port_c_out,
        port_b_out, port_a_out};
    int bad_count = 0, checks = 0;
    always #20 clk = ~clk;
    prl_port_io uut (.*, .port_a_in(pin_v[3:0]), .port_b_in(pin_v[7:4]),
        .port_c_in(pin_v[11:8]), .port_d_in(pin_v[15:12]));
    prl_pins_model pins (.oe(oev), .drv(pv[15:0]), .ext, .pin(pin_v));
    task chk(input logic [29:0] got, input logic [29:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one write, then three idle edges so pin reads settle
    task wr(input logic [3:0] s, input logic [3:0] d, input logic [3:0] dw, input logic [3:0] dv);
        @(posedge clk);
        mem_wr <= 1'h1;
        mem_sel <= s;
        mem_wdata <= d;
        dir_wr <= dw;
        dir_wdata <= dv;
        ext <= 16'($urandom);
        lcd_seg <= 30'($urandom);
        @(posedge clk);
        mem_wr <= 1'h0;
        dir_wr <= 4'h0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // input ports read the board level, all else the written value, except
    // that the sda and scl bits of port a always read the open-drain pad
    function automatic logic [3:0] exp_rd(int p, logic [3:0] d, logic [3:0] dv, logic [15:0] e);
        if (p > 3)
            return d;
        if (!dv[p])
            return e[p*4+:4];
        if (p == 0)
            return {d[3:2] & e[3:2], d[1:0]};
        return d;
    endfunction
    // place one lcd register nibble at its segment positions
    function automatic logic [29:0] lcd_put(logic [29:0] v, int k, logic [3:0] d);
        case (k)
            0: v[25:22] = d;
            1: v[29:26] = d;
            2: v[19:16] = d;
            3: v[21:20] = d[1:0];
            default: v[(k-4)*4+:4] = d;
        endcase
        return v;
    endfunction
    task end_sim;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #400000;
        bad_count++;
        end_sim;
    end
    initial
    begin
        int p;
        logic [3:0] d, dv;
        logic [29:0] lcd_exp, mask;
        p = $urandom(32'hF814);
        @(posedge clk);
        lcd_seg <= 30'($urandom);
        @(posedge clk);
        #1;
        chk(30'(oev), 30'h0);
        chk(seg_pins, 30'h0);
        @(posedge clk);
        rstn <= 1'h1;
        wr(SEL_PORT_A, 4'h6, 4'h0, 4'h0);
        for (int i = 0; i < 60; i++)
        begin
            p = $urandom % 7;
            d = 4'($urandom);
            dv = 4'($urandom);
            wr(SEL_PORT_A + 4'(p), d, 4'hF, dv);
            chk(30'(pv[p*4+:4]), 30'(d));
            chk(30'(mem_rdata), 30'(exp_rd(p, d, dv, ext)));
            chk(30'(oev), 30'({{4{dv[3]}}, {4{dv[2]}}, {4{dv[1]}}, {4{dv[0]}}}));
        end
        wr(SEL_PORT_A, 4'h5, 4'hF, 4'h1);
        chk(30'(mem_rdata), 30'(exp_rd(0, 4'h5, 4'h1, ext)));
        wr(SEL_OUT_ONE, 4'h3, 4'h0, 4'h0);
        @(posedge clk);
        ce_reset <= 1'h1;
        wr(SEL_PORT_A, 4'hA, 4'hF, 4'h1);
        chk(30'(mem_rdata), 30'(ext[3:0]));
        wr(SEL_OUT_ONE, 4'hC, 4'h0, 4'h0);
        chk(30'(port_a_out), 30'h5);
        chk(30'(out_one_pins), 30'h3);
        chk(30'(mem_rdata), 30'h3);
        chk(30'(oev), 30'h0);
        @(posedge clk);
        ce_reset <= 1'h0;
        clk_stop <= 1'h1;
        lcd_port_sel <= 4'h0;
        wr(SEL_OUT_ONE, 4'h9, 4'h0, 4'h0);
        chk(seg_pins, 30'h0);
        chk(30'(out_one_pins), 30'h3);
        chk(30'(port_a_out), 30'h5);
        @(posedge clk);
        clk_stop <= 1'h0;
        lcd_port_sel <= 4'hE;
        wr(SEL_LCD_ONE, 4'h9, 4'h0, 4'h0);
        chk(30'(seg_pins[25:22]), 30'(lcd_seg[25:22]));
        @(posedge clk);
        lcd_port_sel <= 4'hF;
        #1;
        chk(30'(seg_pins[25:22]), 30'h9);
        // every dot and group register nibble, read back and shown as ports
        lcd_exp = 30'h0;
        for (int k = 0; k < 8; k++)
        begin
            d = 4'($urandom);
            wr(SEL_LCD_ONE + 4'(k), d, 4'h0, 4'h0);
            chk(30'(mem_rdata), 30'(k == 3 ? {2'h0, d[1:0]} : d));
            lcd_exp = lcd_put(lcd_exp, k, d);
        end
        chk(seg_pins, lcd_exp);
        // each group chooses port or segment on its own select bit
        repeat (8)
        begin
            @(posedge clk);
            lcd_port_sel <= 4'($urandom);
            lcd_seg <= 30'($urandom);
            #1;
            mask = {{4{lcd_port_sel[1]}}, {4{lcd_port_sel[0]}}, {6{lcd_port_sel[2]}},
                {16{lcd_port_sel[3]}}};
            chk(seg_pins, (lcd_exp & mask) | (lcd_seg & ~mask));
        end
        // power-on reset in mid-run with port a driving and segments live
        @(posedge clk);
        lcd_port_sel <= 4'h0;
        rstn <= 1'h0;
        @(posedge clk);
        #1;
        chk(30'(oev), 30'h0);
        chk(seg_pins, 30'h0);
        @(posedge clk);
        rstn <= 1'h1;
        wr(SEL_LAST, 4'hB, 4'h0, 4'h0);
        chk(30'(oev), 30'h0);
        chk(30'(last_pins), 30'hB);
        end_sim;
    end
endmodule
